// ===== bench/htm_tester.sv
// Board tester model: selectors, power-on straps and port A.
// Assumes the bench calls its tasks just after a clock edge.
// ==========================================
// Tester
module htm_tester (
  output logic       test_select_n0,
  output logic       test_select_n1,
  output logic       power_on_reset_n,
  output logic       user_reset_n,
  output logic       media_changed_in,
  output logic       port_e0_in,
  output logic [7:0] port_a_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels: normal mode, port A at its default
  initial begin
    {test_select_n0, test_select_n1} = 2'h3;
    {power_on_reset_n, user_reset_n} = 2'h3;
    {media_changed_in, port_e0_in} = 2'h0;
    port_a_in = 8'h00;
  end
  // Selector pins
  task automatic sel(input logic n0, input logic n1);
    test_select_n0 <= n0;
    test_select_n1 <= n1;
  endtask
  // Straps; user reset is back to high once released
  task automatic por(input logic low, input logic mc, input logic pe0, input logic ur);
    power_on_reset_n <= ~low;
    media_changed_in <= mc;
    port_e0_in <= pe0;
    user_reset_n <= low ? ur : 1'b1;
  endtask
  // Non-default codes only in the bus test and from the clock test to the end of the run
  task automatic porta(input logic [7:0] v);
    port_a_in <= v;
  endtask
endmodule

// ===== bench/test_hardware_test_mode_control.sv
// Self-checking bench of the test-mode control.
// Assumes the tester model drives selectors, straps and port A.
// ==========================================
// Bench
module test_hardware_test_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = htm_pkg::NPAD;
  // Stimulus, all defined at time zero
  logic        clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        main_crystal_in = 1'b0, rtc_crystal_pin = 1'b0, main_synth_out = 1'b0, osc_run = 1'b1;
  logic        periph_test_ack = 1'b0, word_func = 1'b0, port_c0_func = 1'b1;
  logic        cpu_irq_n = 1'b1, cpu_fast_irq_n = 1'b1, ext_access = 1'b0, periph_access = 1'b0;
  logic [7:0]  paddr = 8'h00, column_func = 8'h80;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [W-1:0] pad_in = '0, func_out = '0, func_oe = '1, pad_out, pad_oe;
  logic [3:0]  port_e_func = 4'h0, port_e_out;
  logic [2:0]  ext_region = 3'h0;
  logic [1:0]  width_field = 2'h0, bus_width;
  // Observed outputs and tester pins
  logic [7:0]  port_a_in, column_drive, exp_select_n, sel_exp;
  logic [5:0]  synth_ctrl;
  logic        pready, pslverr, err, main_clk_direct, core_hold, boot_8bit, test_rom_mode;
  logic        word_pin_out, port_c0_out, periph_test_ctrl_a, periph_test_ctrl_b;
  logic        rtc_divider_fast_start, periph_test_clock_in, video_count_speedup;
  logic        test_select_n0, test_select_n1, power_on_reset_n, user_reset_n, media_changed_in, port_e0_in;
  int          num_errors = 0, n_tests = 0, cycles = 0;

  htm_tester tester (.*);
  htm_test_ctrl DUT (.*);

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  // Hang guard, far above the 120 or so cycles used
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude;
    end
  end

  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Straps sampled while power-on reset is low, then released
  task automatic strap(input logic mc, input logic pe0, input logic ur);
    @(posedge clk_sys);
    tester.por(1'b1, mc, pe0, ur);
    repeat (2) @(posedge clk_sys);
    tester.por(1'b0, mc, pe0, ur);
    @(negedge clk_sys);
  endtask
  task automatic conclude;
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    strap(1'b0, 1'b1, 1'b1);
    chk(boot_8bit, 1'b1);
    apb(1'b0, htm_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, 32'h150);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, htm_pkg::CTRL_OFFSET, 32'h800);
    apb(1'b0, htm_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h800);
    periph_access <= 1'b1;
    cpu_irq_n <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(exp_select_n, 8'hBF);
    chk(port_e_out[2:1], 2'h2);
    // Bypass: oscillator enable replaces the port function
    @(posedge clk_sys);
    periph_access <= 1'b0;
    tester.sel(1'b1, 1'b0);
    osc_run <= 1'b0;
    @(negedge clk_sys);
    chk(main_clk_direct, 1'b1);
    chk(synth_ctrl, htm_pkg::SYNTH_OFF);
    chk(port_c0_out, 1'b0);
    // Bus test
    @(posedge clk_sys);
    tester.sel(1'b0, 1'b1);
    tester.porta(8'h15);
    periph_test_ack <= 1'b1;
    @(negedge clk_sys);
    chk(synth_ctrl, htm_pkg::SYNTH_EPB);
    chk({video_count_speedup, periph_test_clock_in, rtc_divider_fast_start,
         periph_test_ctrl_b, periph_test_ctrl_a}, 5'h15);
    chk(word_pin_out, 1'b1);
    // Clock test needs user reset latched low
    @(posedge clk_sys);
    tester.porta(8'h00);
    strap(1'b0, 1'b0, 1'b0);
    chk(core_hold, 1'b1);
    chk(synth_ctrl, htm_pkg::SYNTH_INVERT);
    @(posedge clk_sys);
    tester.porta(8'h01);
    main_synth_out <= 1'b1;
    rtc_crystal_pin <= 1'b1;
    @(negedge clk_sys);
    chk(synth_ctrl, 6'h3B);
    chk(column_drive[2:0], 3'h5);
    // 32 sampled main crystal rises set the divider's top bit
    repeat (64) @(posedge clk_sys) main_crystal_in <= ~main_crystal_in;
    @(negedge clk_sys);
    chk(column_drive[4], 1'b1);
    // High-Z while functional enables are all on
    @(posedge clk_sys);
    tester.sel(1'b0, 1'b0);
    @(negedge clk_sys);
    chk(pad_oe, '0);
    // Pin test, entered from normal after straps
    @(posedge clk_sys);
    tester.sel(1'b1, 1'b1);
    strap(1'b0, 1'b0, 1'b1);
    chk(column_drive[7], 1'b1);
    @(posedge clk_sys);
    tester.sel(1'b0, 1'b0);
    pad_in <= 16'hA5C3;
    @(negedge clk_sys);
    chk(pad_oe, 16'hFFFF);
    chk(column_drive[7], 1'b0);
    @(posedge clk_sys);
    pad_in <= 16'h0001;
    @(negedge clk_sys);
    chk(pad_out, 16'hA5C3);
    chk(column_drive[7], 1'b1);
    // Test ROM: reversed selects and width codes
    @(posedge clk_sys);
    tester.sel(1'b1, 1'b1);
    strap(1'b1, 1'b0, 1'b1);
    chk(test_rom_mode, 1'b1);
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_sys);
      ext_access <= 1'b1;
      ext_region <= r[2:0];
      width_field <= r[1:0];
      sel_exp = ~(8'h80 >> r);
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk(exp_select_n, sel_exp);
      chk(bus_width, r[1:0]);
    end
    conclude;
  end
endmodule

// ===== core/htm_regs.sv
// APB register file of the test-mode control.
// Assumes an APB master on clk_sys; answers with no wait state.
// ==========================================
// Register file
module htm_regs (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  htm_reg_if.regs          bus
);
  logic setup;   // Setup cycle of a transfer
  logic hit;     // Address maps to a register
  logic access;  // Access phase completes now
  assign setup = psel && !penable;
  assign hit = (paddr == htm_pkg::CTRL_OFFSET) || (paddr == htm_pkg::STATUS_OFFSET);
  assign access = psel && penable;
  // Zero wait states, so pready is a plain level
  assign pready = 1'b1;

  // ==========================================
  // Control register write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus.soft_test <= htm_pkg::CTRL_SOFT_TEST_RESET;
    end else if (access && pwrite && paddr == htm_pkg::CTRL_OFFSET) begin
      bus.soft_test <= pwdata[htm_pkg::CTRL_SOFT_TEST_BIT];
    end
  end

  // ==========================================
  // Read data and error, prepared in the setup cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= 32'h0000_0000;
      pslverr <= !hit;  // Unmapped address answers an error
      if (!pwrite && paddr == htm_pkg::CTRL_OFFSET) begin
        prdata[htm_pkg::CTRL_SOFT_TEST_BIT] <= bus.soft_test;
      end else if (!pwrite && paddr == htm_pkg::STATUS_OFFSET) begin
        prdata[htm_pkg::ST_MODE_LSB +: 3] <= bus.mode;
        prdata[htm_pkg::ST_BOOT8_BIT] <= bus.boot_8bit;
        prdata[htm_pkg::ST_ROM_BIT]   <= bus.test_rom;
        prdata[htm_pkg::ST_UR_BIT]    <= bus.latch_ur;
        prdata[htm_pkg::ST_MC_BIT]    <= bus.latch_mc;
        prdata[htm_pkg::ST_PE0_BIT]   <= bus.latch_pe0;
      end
    end
  end

  // ==========================================
  // Checks
  sequence s_ctrl_wr;
    access && pwrite && paddr == htm_pkg::CTRL_OFFSET;
  endsequence
  property p_ctrl_wr;
    @(posedge clk_sys) disable iff (!reset_n)
      s_ctrl_wr |=> bus.soft_test == $past(pwdata[11]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control bit not stored");
  property p_ctrl_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      !(access && pwrite) |=> $stable(bus.soft_test);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control bit moved");
endmodule

// ===== core/htm_test_ctrl.sv
// Hardware test-mode control: strap latching, mode decode, pad
// steering, clock test outputs, chip select and width decode.
// Assumes pins are synchronous to clk_sys; the pad bank stands
// for every signal pin except the two test selectors.
// ==========================================
// Summary of operation
// - Straps follow pins while power-on reset low
// - Both selectors high: normal, strap picks width
// - Bypass mode: oscillators and loop off
// - Bypass: oscillator enable on port C0
// - Selector 1 only, user reset high: bus test
// - Bus test: port A controls, word acknowledge
// - Clock test: logic frozen except dividers
// - Clock test: port A drives synthesiser
// - Clock test: clocks on column drives
// - Some synthesiser inputs inverted, zero is default
// - Pin test: column 7 is pad parity
// - Pin test entry: latch pads, drive back
// - Parity chain gated off outside pin test
// - High-Z mode: all output enables off
// - Media-changed strap selects test ROM boot
// - Test ROM: chip select decode reversed
// - Test ROM: bus width field decode
// - Control bit 11 mirrors bus on select 6
// - Soft test: interrupts out on port E
module htm_test_ctrl (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    test_select_n0,
  input  wire logic                    test_select_n1,
  input  wire logic                    power_on_reset_n,
  input  wire logic                    user_reset_n,
  input  wire logic                    media_changed_in,
  input  wire logic                    port_e0_in,
  input  wire logic [7:0]              port_a_in,
  input  wire logic                    main_crystal_in,
  input  wire logic                    rtc_crystal_pin,
  input  wire logic                    main_synth_out,
  input  wire logic                    osc_run,
  output logic                         main_clk_direct,
  output logic      [5:0]              synth_ctrl,
  output logic                         core_hold,
  output logic                         boot_8bit,
  output logic                         test_rom_mode,
  output logic                         periph_test_ctrl_a,
  output logic                         periph_test_ctrl_b,
  output logic                         rtc_divider_fast_start,
  output logic                         periph_test_clock_in,
  output logic                         video_count_speedup,
  input  wire logic                    periph_test_ack,
  input  wire logic                    word_func,
  output logic                         word_pin_out,
  input  wire logic                    port_c0_func,
  output logic                         port_c0_out,
  input  wire logic [3:0]              port_e_func,
  input  wire logic                    cpu_irq_n,
  input  wire logic                    cpu_fast_irq_n,
  output logic      [3:0]              port_e_out,
  input  wire logic [7:0]              column_func,
  output logic      [7:0]              column_drive,
  input  wire logic [htm_pkg::NPAD-1:0] pad_in,
  input  wire logic [htm_pkg::NPAD-1:0] func_out,
  input  wire logic [htm_pkg::NPAD-1:0] func_oe,
  output logic      [htm_pkg::NPAD-1:0] pad_out,
  output logic      [htm_pkg::NPAD-1:0] pad_oe,
  input  wire logic                    ext_access,
  input  wire logic                    periph_access,
  input  wire logic [2:0]              ext_region,
  input  wire logic [1:0]              width_field,
  output logic      [7:0]              exp_select_n,
  output logic      [1:0]              bus_width
);
  // ==========================================
  // Functions
  // Select index for a 256 MB region
  function automatic logic [2:0] sel_index(input logic [2:0] region, input logic rom);
    sel_index = rom ? 3'h7 - region : region;
  endfunction
  // Transfer width from the width field
  function automatic htm_pkg::htm_width_type width_of(input logic [1:0] f, input logic rom);
    width_of = htm_pkg::htm_width_type'(rom ? f : {~f[1], f[0]});
  endfunction

  // ==========================================
  // Declarations
  htm_reg_if                 rif ();       // Link to register file
  htm_pkg::htm_mode_type     mode;         // Decoded mode
  htm_pkg::htm_mode_type     mode_q;       // Mode one cycle ago
  logic                      latch_ur;     // User reset strap
  logic                      latch_mc;     // Media-changed strap
  logic                      latch_pe0;    // Port E bit 0 strap
  logic [htm_pkg::NPAD-1:0]  pin_hold;     // Pad levels at pin test entry
  logic [htm_pkg::NPAD-1:0]  parity_feed;  // Gated parity inputs
  logic                      parity;       // Pad parity
  logic                      main_q;       // Main crystal, last sample
  logic                      rtc_q;        // RTC crystal, last sample
  logic [htm_pkg::RIPPLE_WIDTH-1:0]  ripple;   // 576 kHz divider
  logic [htm_pkg::RTC_DIV_WIDTH-1:0] rtc_div;  // 1 Hz divider
  logic                      sel_strobe;   // Any select strobe asked
  logic [2:0]                sel_idx;      // Strobe index

  // ==========================================
  // Register file
  htm_regs u_regs (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (rif)
  );
  assign rif.mode = mode;
  assign rif.boot_8bit = boot_8bit;
  assign rif.test_rom = test_rom_mode;
  assign rif.latch_ur = latch_ur;
  assign rif.latch_mc = latch_mc;
  assign rif.latch_pe0 = latch_pe0;

  // ==========================================
  // Straps
  // Follow pins while power-on reset is low; the last low level
  // stays when it rises, so pins serve normally afterwards
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      latch_ur  <= htm_pkg::UR_STRAP_RESET;
      latch_mc  <= htm_pkg::STRAP_RESET;
      latch_pe0 <= htm_pkg::STRAP_RESET;
    end else if (!power_on_reset_n) begin
      latch_ur  <= user_reset_n;
      latch_mc  <= media_changed_in;
      latch_pe0 <= port_e0_in;
    end
  end

  // ==========================================
  // Mode decode, straight from the selector pins and the latched user reset strap
  always_comb begin
    case ({test_select_n0, test_select_n1})
      2'b11:   mode = htm_pkg::HTM_NORMAL;
      2'b10:   mode = htm_pkg::HTM_BYPASS;
      2'b01:   mode = latch_ur ? htm_pkg::HTM_EPB : htm_pkg::HTM_OSC;
      2'b00:   mode = latch_ur ? htm_pkg::HTM_PIN : htm_pkg::HTM_HIGHZ;
      default: mode = htm_pkg::HTM_NORMAL;
    endcase
  end

  // Boot selection, only meaningful with both selectors high
  assign test_rom_mode = latch_mc;
  assign boot_8bit = latch_mc || latch_pe0;
  // Freeze all logic but the two dividers
  assign core_hold = (mode == htm_pkg::HTM_OSC);
  assign main_clk_direct = (mode == htm_pkg::HTM_BYPASS);

  // ==========================================
  // Synthesiser controls
  always_comb begin
    case (mode)
      htm_pkg::HTM_BYPASS: synth_ctrl = htm_pkg::SYNTH_OFF;
      htm_pkg::HTM_EPB:    synth_ctrl = htm_pkg::SYNTH_EPB;
      // An idle port gives the default settings
      htm_pkg::HTM_OSC:    synth_ctrl = port_a_in[5:0] ^ htm_pkg::SYNTH_INVERT;
      default:             synth_ctrl = htm_pkg::SYNTH_INVERT;
    endcase
  end

  // ==========================================
  // Bus test inputs and acknowledge
  always_comb begin
    periph_test_ctrl_a     = 1'b0;
    periph_test_ctrl_b     = 1'b0;
    rtc_divider_fast_start = 1'b0;
    periph_test_clock_in   = 1'b0;
    video_count_speedup    = 1'b0;
    word_pin_out           = word_func;
    if (mode == htm_pkg::HTM_EPB) begin
      periph_test_ctrl_a     = port_a_in[0];
      periph_test_ctrl_b     = port_a_in[1];
      rtc_divider_fast_start = port_a_in[2];
      periph_test_clock_in   = port_a_in[3];
      video_count_speedup    = port_a_in[4];
      word_pin_out           = periph_test_ack;
    end
  end

  // External oscillator enable replaces port C bit 0
  assign port_c0_out = main_clk_direct ? osc_run : port_c0_func;

  // Interrupt lines replace port E bits 1 and 2; software must
  // still make those bits outputs to see them
  assign port_e_out = rif.soft_test ? {port_e_func[3], cpu_fast_irq_n, cpu_irq_n, port_e_func[0]}
                                    : port_e_func;

  // ==========================================
  // Dividers
  // Crystal inputs are sampled; they must stay well below half
  // the system rate, so this is a slow functional model
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      main_q <= 1'b0;
      rtc_q  <= 1'b0;
    end else begin
      main_q <= main_crystal_in;
      rtc_q  <= rtc_crystal_pin;
    end
  end

  // Main clock divided by 64 gives 576 kHz
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ripple <= '0;
    end else if (main_crystal_in && !main_q) begin
      ripple <= ripple + 1'b1;
    end
  end

  // RTC clock divided down to 1 Hz
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rtc_div <= '0;
    end else if (rtc_crystal_pin && !rtc_q) begin
      rtc_div <= rtc_div + 1'b1;
    end
  end

  // ==========================================
  // Pin test pad bank
  // Catch every pad on the first cycle of pin test
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q   <= htm_pkg::HTM_NORMAL;
      pin_hold <= '0;
    end else begin
      mode_q <= mode;
      if (mode == htm_pkg::HTM_PIN && mode_q != htm_pkg::HTM_PIN) begin
        pin_hold <= pad_in;
      end
    end
  end

  // Gating the feed keeps the chain still and saves power
  assign parity_feed = (mode == htm_pkg::HTM_PIN) ? pad_in : '0;
  assign parity = ^parity_feed;

  // High-Z is pure logic from pins and strap, no clock edge
  always_comb begin
    case (mode)
      htm_pkg::HTM_HIGHZ: begin
        pad_out = func_out;
        pad_oe  = '0;
      end
      htm_pkg::HTM_PIN: begin
        // The entry cycle still drives live pads
        pad_out = (mode_q == htm_pkg::HTM_PIN) ? pin_hold : pad_in;
        pad_oe  = '1;
      end
      default: begin
        pad_out = func_out;
        pad_oe  = func_oe;
      end
    endcase
  end

  // ==========================================
  // Column drives
  always_comb begin
    column_drive = column_func;
    if (mode == htm_pkg::HTM_OSC) begin
      column_drive[0] = rtc_crystal_pin;
      column_drive[1] = rtc_div[htm_pkg::RTC_DIV_WIDTH-1];
      column_drive[2] = main_synth_out;
      column_drive[4] = ripple[htm_pkg::RIPPLE_WIDTH-1];
    end
    if (mode == htm_pkg::HTM_PIN) begin
      column_drive[7] = parity;
    end
  end

  // ==========================================
  // Expansion selects and width, registered
  assign sel_strobe = ext_access || (rif.soft_test && periph_access);
  // Mirrored peripheral cycles always use select 6
  assign sel_idx = (rif.soft_test && periph_access) ? 3'h6
                 : sel_index(ext_region, test_rom_mode);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      exp_select_n <= 8'hFF;
      bus_width    <= 2'h0;
    end else begin
      exp_select_n <= sel_strobe ? ~(8'h01 << sel_idx) : 8'hFF;
      bus_width    <= width_of(width_field, test_rom_mode);
    end
  end

  // ==========================================
  // Checks
  property p_strap_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      power_on_reset_n && $past(power_on_reset_n) |-> $stable(latch_ur) && $stable(latch_mc);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap moved after reset");
  property p_bypass_c0;
    @(posedge clk_sys) disable iff (!reset_n)
      !test_select_n1 && test_select_n0 |-> port_c0_out == osc_run && synth_ctrl == 6'h23;
  endproperty
  a_bypass_c0: assert property (p_bypass_c0) else $error("bypass outputs wrong");
  property p_highz;
    @(posedge clk_sys) disable iff (!reset_n)
      !test_select_n0 && !test_select_n1 && !latch_ur |-> pad_oe == '0;
  endproperty
  a_highz: assert property (p_highz) else $error("pad driven in high-z");
  sequence s_pin_enter;
    mode == htm_pkg::HTM_PIN && mode_q != htm_pkg::HTM_PIN;
  endsequence
  property p_pin_drive;
    @(posedge clk_sys) disable iff (!reset_n)
      s_pin_enter ##1 mode == htm_pkg::HTM_PIN |-> pad_out == $past(pad_in) && pad_oe == '1;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin test not driving latched pads");
  property p_parity_off;
    @(posedge clk_sys) disable iff (!reset_n)
      mode != htm_pkg::HTM_PIN |-> !parity && column_drive[7] == column_func[7];
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity chain active");
  property p_osc_default;
    @(posedge clk_sys) disable iff (!reset_n)
      mode == htm_pkg::HTM_OSC && port_a_in[5:0] == 6'h00 |-> synth_ctrl == 6'h3A && core_hold;
  endproperty
  a_osc_default: assert property (p_osc_default) else $error("default controls wrong");
  property p_rom_region0;
    @(posedge clk_sys) disable iff (!reset_n)
      ext_access && !periph_access && latch_mc && ext_region == 3'h0 |=> exp_select_n == 8'h7F;
  endproperty
  a_rom_region0: assert property (p_rom_region0) else $error("test ROM decode wrong");
  property p_irq_out;
    @(posedge clk_sys) disable iff (!reset_n)
      rif.soft_test |-> port_e_out[1] == cpu_irq_n && port_e_out[2] == cpu_fast_irq_n;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupts not exported");
  property p_epb_bp;
    @(posedge clk_sys) disable iff (!reset_n)
      mode == htm_pkg::HTM_EPB |-> synth_ctrl[0] && word_pin_out == periph_test_ack;
  endproperty
  a_epb_bp: assert property (p_epb_bp) else $error("bus test outputs wrong");
endmodule

// ===== include/htm_pkg.sv
// Constants and types of the hardware test-mode control.
// Assumes one 10 MHz system clock and an APB register port.
// ==========================================
// Package
package htm_pkg;
  // Signal pads in the generic pad bank
  localparam int NPAD = 16;
  // Clock rate and divider lengths
  localparam int CLK_SYS_HZ = 10_000_000;
  localparam int RIPPLE_WIDTH = 6;          // Main clock / 64
  localparam int RTC_DIV_WIDTH = 15;        // 32768 Hz down to 1 Hz
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // Control register layout and reset value
  localparam int CTRL_SOFT_TEST_BIT = 11;
  localparam logic CTRL_SOFT_TEST_RESET = 1'b0;
  // Status register layout
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BOOT8_BIT = 4;
  localparam int ST_ROM_BIT = 5;
  localparam int ST_UR_BIT = 6;
  localparam int ST_MC_BIT = 7;
  localparam int ST_PE0_BIT = 8;
  // Synthesiser controls, port A order {sel,xtal,on,d0,d1,bp}
  localparam logic [5:0] SYNTH_INVERT = 6'h3A;  // Equals default
  localparam logic [5:0] SYNTH_OFF = 6'h23;     // Osc and loop off
  localparam logic [5:0] SYNTH_EPB = 6'h3B;     // Default, bypassed
  localparam int SYNTH_BP_BIT = 0;
  // Latched strap reset values
  localparam logic STRAP_RESET = 1'b0;
  localparam logic UR_STRAP_RESET = 1'b1;
  // Hardware test modes
  typedef enum logic [2:0] {
    HTM_NORMAL, HTM_BYPASS, HTM_EPB, HTM_OSC, HTM_PIN, HTM_HIGHZ
  } htm_mode_type;
  // Expansion transfer widths, coded as the test-ROM field
  typedef enum logic [1:0] {
    HTM_W8, HTM_PCMCIA, HTM_W32, HTM_W16
  } htm_width_type;
endpackage

// ===== include/htm_reg_if.sv
// Carrier between the test-mode core and its register file.
// Assumes both ends sit on clk_sys.
// ==========================================
// Interface
interface htm_reg_if;
  logic                 soft_test;  // Mirror and interrupt export
  htm_pkg::htm_mode_type mode;      // Decoded hardware mode
  logic                 boot_8bit;  // Boot width in use
  logic                 test_rom;   // Test ROM straps latched
  logic                 latch_ur;   // Latched user reset level
  logic                 latch_mc;   // Latched media-changed level
  logic                 latch_pe0;  // Latched port E bit 0
  modport core (input soft_test, output mode, boot_8bit,
                output test_rom, latch_ur, latch_mc, latch_pe0);
  modport regs (output soft_test, input mode, boot_8bit,
                input test_rom, latch_ur, latch_mc, latch_pe0);
endinterface
